// ==== dcf_regs.vh ====
// Register offsets, field positions, reset values and timing counts of the coefficient FIR block
// Overview of operation
// - Coefficient base comes from the profile pointer, or the override register when enabled.
// - Each block is one 112-bit write to 0xC7, read as eight 14-bit values.
// - Coefficient k occupies bits 14k+13 down to 14k of the block.
// - Stored coefficients are signed two's complement 14-bit numbers.
// - Block is shifted in from coefficient 7 bit 13 down to coefficient 0 bit 0.
// - Pointer advances by one after every complete block write.
// - Tap test mode streams stored coefficients to the output instead of filtered data.
// - Test readout: zero, serpentine coefficient walk, mirrored walk back, then zeros until the next trigger.
// - After the last coefficient the readout replays in reverse to the first.
// - Sync input is latched on the first ADC clock falling edge after it rises.
// - Frame marker starts 16 plus ratio plus 1 ADC periods after the latched edge.
// - Decimation uses a symmetric 16 times M tap FIR, M 1 to 32, half stored.
// - Output is the sum of delayed inputs times coefficients, index n at delay n.
// - With control bit 10 set, the mixer phase resets on each trigger.
// - The 16-bit frame marker word comes from a writable register.
// - Coefficient n sits at position I of block j with n = M(1+I)-(1+j).
// - New coefficient base, profile fields and ratio take effect only at the next trigger.
`ifndef DCF_REGS_VH
`define DCF_REGS_VH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define DCF_ADDR_TRIG 8'h00
`define DCF_ADDR_CTRL 8'h0A
`define DCF_ADDR_MARK 8'h0B
`define DCF_ADDR_SHIFT 8'h1D
`define DCF_ADDR_MAN 8'h1F
`define DCF_ADDR_PTR 8'hC6
`define DCF_ADDR_COEF 8'hC7
`define DCF_ADDR_MASK 8'h3F
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define DCF_TRIG_BIT 2
`define DCF_CTRL_OFFSKIP 0
`define DCF_CTRL_MIXSKIP 2
`define DCF_CTRL_PHRST 10
`define DCF_CTRL_SCALE 13
`define DCF_CTRL_REMSKIP 14
`define DCF_SHF_VAL_HI 6
`define DCF_SHF_VAL_LO 4
`define DCF_SHF_EN 7
`define DCF_SHF_TEST 8
`define DCF_MAN_EN 15
`define DCF_MAN_HI 14
`define DCF_MAN_LO 7
// ---------------------------------------------------------------
// Reset values and frame lengths
// ---------------------------------------------------------------
`define DCF_CTRL_RST 16'h0000
`define DCF_MARK_RST 16'h0000
`define DCF_SHIFT_RST 16'h0000
`define DCF_MAN_RST 16'h0000
`define DCF_PTR_RST 8'h00
`define DCF_FRAME_SHORT 8'h18
`define DCF_FRAME_LONG 8'h78
// ---------------------------------------------------------------
// Timing counts in ADC clock periods
// ---------------------------------------------------------------
`define DCF_MARK_BASE 10'h010
`define DCF_MARK_EXTRA 10'h001
`define DCF_RATIO_MAX 6'h20
`endif

// ==== dcf_core.v ====
// Coefficient memory, trigger timing, decimating FIR and tap test readout
`timescale 1ns/10ps
`default_nettype none
`include "dcf_regs.vh"
module dcf_core #(
   parameter HIST_AW = 9
) (
   // Clock and reset
   input wire sys_clk,
   input wire rst_n,
   // Serial port pins
   input wire sclk,
   input wire sen_n,
   input wire sdata,
   input wire demod_port_select,
   // ADC sample side
   input wire adc_clk,
   input wire tx_sync,
   input wire [13:0] adc_data,
   // Active profile fields
   input wire [7:0] prof_coef_ptr,
   input wire [5:0] prof_dec_ratio,
   // Static controls and mixer phase reset pulse
   output wire offset_removal_skip,
   output wire mixer_skip,
   output wire remodulator_skip,
   output reg mixer_phase_reset,
   // Result stream
   output wire [15:0] out_word,
   output wire out_marker,
   output wire out_valid,
   input wire out_ready
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function hit;
      input [7:0] a;
      input [7:0] r;
      begin
         hit = ((a & `DCF_ADDR_MASK) == (r & `DCF_ADDR_MASK));
      end
   endfunction
   function [13:0] pick14;
      input [111:0] w;
      input [2:0] i;
      reg [111:0] t;
      begin
         t = w >> ({4'h0, i} * 7'h0E);
         pick14 = t[13:0];
      end
   endfunction
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   wire [5:0] pins = {demod_port_select, tx_sync, adc_clk, sdata, sen_n, sclk};
   reg [5:0] p1_r, p2_r, p3_r, lv_r, lq_r;
   reg [13:0] d1_r, d2_r, d3_r;
   wire [5:0] lv_nxt = ((p2_r ~^ p3_r) & p3_r) | ((p2_r ^ p3_r) & lv_r);
   wire [5:0] rise = lv_r & ~lq_r;
   wire [5:0] fall = ~lv_r & lq_r;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         p1_r <= 6'h3F;
         p2_r <= 6'h3F;
         p3_r <= 6'h3F;
         lv_r <= 6'h3F;
         lq_r <= 6'h3F;
         d1_r <= 14'h0000;
         d2_r <= 14'h0000;
         d3_r <= 14'h0000;
      end else begin
         p1_r <= pins;
         p2_r <= p1_r;
         p3_r <= p2_r;
         lv_r <= lv_nxt;
         lq_r <= lv_r;
         d1_r <= adc_data;
         d2_r <= d1_r;
         d3_r <= d2_r;
      end
   end

   // ---------------------------------------------------------------
   // Serial write port
   // ---------------------------------------------------------------
   reg [119:0] sh_r;
   reg [7:0] bc_r;
   wire commit = rise[1] & ~lv_r[5];
   wire wr16 = commit & (bc_r == `DCF_FRAME_SHORT);
   wire wr112 = commit & (bc_r == `DCF_FRAME_LONG) & hit(sh_r[119:112], `DCF_ADDR_COEF);
   wire [7:0] a16 = sh_r[23:16];
   wire [15:0] d16 = sh_r[15:0];

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_r <= 120'h0;
         bc_r <= 8'h00;
      end else if (fall[1]) begin
         bc_r <= 8'h00;
      end else if (!lv_r[1] && rise[0]) begin
         sh_r <= {sh_r[118:0], lv_r[2]};
         if (bc_r != 8'hFF) begin
            bc_r <= bc_r + 8'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   reg [15:0] ctrl_r, mark_r, shf_r, man_r;
   reg [7:0] ptr_r;
   wire man_trig = wr16 & hit(a16, `DCF_ADDR_TRIG) & d16[`DCF_TRIG_BIT];
   assign offset_removal_skip = ctrl_r[`DCF_CTRL_OFFSKIP];
   assign mixer_skip = ctrl_r[`DCF_CTRL_MIXSKIP];
   assign remodulator_skip = ctrl_r[`DCF_CTRL_REMSKIP];
   wire tst_en = shf_r[`DCF_SHF_TEST];

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= `DCF_CTRL_RST;
         mark_r <= `DCF_MARK_RST;
         shf_r <= `DCF_SHIFT_RST;
         man_r <= `DCF_MAN_RST;
         ptr_r <= `DCF_PTR_RST;
      end else if (wr112) begin
         ptr_r <= ptr_r + 8'h01;
      end else if (wr16) begin
         if (hit(a16, `DCF_ADDR_CTRL)) begin
            ctrl_r <= d16;
         end
         if (hit(a16, `DCF_ADDR_MARK)) begin
            mark_r <= d16;
         end
         if (hit(a16, `DCF_ADDR_SHIFT)) begin
            shf_r <= d16;
         end
         if (hit(a16, `DCF_ADDR_MAN)) begin
            man_r <= d16;
         end
         if (hit(a16, `DCF_ADDR_PTR)) begin
            ptr_r <= d16[7:0];
         end
      end
   end

   // Coefficient memory, not reset
   reg [111:0] cmem [0:255];
   always @(posedge sys_clk) begin
      if (wr112) begin
         cmem[ptr_r] <= sh_r[111:0];
      end
   end

   // ---------------------------------------------------------------
   // Trigger and frame marker timing
   // ---------------------------------------------------------------
   reg armed_r, run_r;
   reg [7:0] base_r;
   reg [5:0] m_r, dph_r;
   reg [9:0] kc_r;
   wire trig = fall[3] & armed_r;
   wire go = trig | man_trig;
   wire [5:0] m_new = (prof_dec_ratio == 6'h00) ? 6'h01 :
                      (prof_dec_ratio > `DCF_RATIO_MAX) ? `DCF_RATIO_MAX : prof_dec_ratio;
   wire [9:0] k_new = {4'h0, m_new} + `DCF_MARK_BASE + `DCF_MARK_EXTRA;
   wire [5:0] m1 = m_r - 6'h01;
   wire smp = rise[3];
   wire slot = smp & run_r & (dph_r == 6'h00);
   reg mk_pend_r;
   wire mk_take;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_r <= 1'b0;
         run_r <= 1'b0;
         base_r <= 8'h00;
         m_r <= 6'h01;
         dph_r <= 6'h00;
         kc_r <= 10'h000;
         mk_pend_r <= 1'b0;
         mixer_phase_reset <= 1'b0;
      end else begin
         mixer_phase_reset <= go & ctrl_r[`DCF_CTRL_PHRST];
         if (rise[4]) begin
            armed_r <= 1'b1;
         end else if (fall[3]) begin
            armed_r <= 1'b0;
         end
         if (go) begin
            base_r <= man_r[`DCF_MAN_EN] ? man_r[`DCF_MAN_HI:`DCF_MAN_LO] : prof_coef_ptr;
            m_r <= m_new;
            kc_r <= k_new;
            run_r <= 1'b0;
         end else if (fall[3] && kc_r != 10'h000) begin
            kc_r <= kc_r - 10'h001;
            if (kc_r == 10'h001) begin
               run_r <= 1'b1;
               dph_r <= 6'h00;
            end
         end else if (smp && run_r) begin
            dph_r <= (dph_r == m1) ? 6'h00 : dph_r + 6'h01;
         end
         if (fall[3] && !go && kc_r == 10'h001) begin
            mk_pend_r <= 1'b1;
         end else if (mk_take) begin
            mk_pend_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Sample history
   // ---------------------------------------------------------------
   reg [13:0] hist [0:(1 << HIST_AW) - 1];
   reg [HIST_AW-1:0] hp_r;
   always @(posedge sys_clk) begin
      if (smp) begin
         hist[hp_r] <= d3_r;
      end
   end

   // ---------------------------------------------------------------
   // Tap test readout
   // ---------------------------------------------------------------
   reg [9:0] tc_r;
   reg tst_pend_r;
   reg [15:0] tst_val_r;
   wire tst_take;
   wire [9:0] m16 = {m_r, 4'h0};
   wire [9:0] m8 = {1'b0, m_r, 3'h0};
   wire [9:0] ts = tc_r - 10'h001;
   wire [9:0] tp = (ts < m8) ? ts : (m16 - 10'h001 - ts);
   wire [5:0] tj = tp[8:3];
   wire [2:0] ti = tp[2:0] ^ {3{tj[0]}};
   wire [13:0] tcoef = pick14(cmem[base_r + {2'h0, tj}], ti);
   wire tzero = (tc_r == 10'h000) || (tc_r > m16);

   // ---------------------------------------------------------------
   // FIR engine, one tap per cycle
   // ---------------------------------------------------------------
   reg busy_r, half_r, done_r;
   reg [2:0] ei_r;
   reg [5:0] ej_r;
   reg [HIST_AW-1:0] hs_r, off_r;
   reg signed [39:0] acc_r;
   reg [15:0] res_r;
   wire eng_take;
   wire signed [13:0] ecoef = pick14(cmem[base_r + {2'h0, ej_r}], ei_r);
   wire signed [13:0] esmp = hist[hs_r - off_r];
   wire signed [27:0] prod = ecoef * esmp;
   wire signed [39:0] acc_nxt = acc_r + {{12{prod[27]}}, prod};
   wire last = half_r & (ej_r == m1) & (ei_r == 3'h0);
   wire [3:0] sh = shf_r[`DCF_SHF_EN] ? {ctrl_r[`DCF_CTRL_SCALE], shf_r[`DCF_SHF_VAL_HI:`DCF_SHF_VAL_LO]} : 4'h0;
   wire signed [39:0] shv = acc_nxt >>> sh;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hp_r <= {HIST_AW{1'b0}};
         tc_r <= 10'h000;
         tst_pend_r <= 1'b0;
         tst_val_r <= 16'h0000;
         busy_r <= 1'b0;
         half_r <= 1'b0;
         done_r <= 1'b0;
         ei_r <= 3'h0;
         ej_r <= 6'h00;
         hs_r <= {HIST_AW{1'b0}};
         off_r <= {HIST_AW{1'b0}};
         acc_r <= 40'h0;
         res_r <= 16'h0000;
      end else begin
         if (smp) begin
            hp_r <= hp_r + 1'b1;
         end
         if (tst_take) begin
            tst_pend_r <= 1'b0;
         end
         if (go) begin
            tc_r <= 10'h000;
         end else if (slot && tst_en) begin
            tst_pend_r <= 1'b1;
            tst_val_r <= tzero ? 16'h0000 : {{2{tcoef[13]}}, tcoef};
            if (tc_r <= m16) begin
               tc_r <= tc_r + 10'h001;
            end
         end
         if (eng_take) begin
            done_r <= 1'b0;
         end
         if (slot && !tst_en && !busy_r && !done_r) begin
            busy_r <= 1'b1;
            half_r <= 1'b0;
            ei_r <= 3'h0;
            ej_r <= m1;
            hs_r <= hp_r;
            off_r <= {HIST_AW{1'b0}};
            acc_r <= 40'h0;
         end else if (busy_r) begin
            acc_r <= acc_nxt;
            off_r <= off_r + 1'b1;
            if (last) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
               res_r <= shv[15:0];
            end else if (!half_r) begin
               if (ej_r != 6'h00) begin
                  ej_r <= ej_r - 6'h01;
               end else if (ei_r == 3'h7) begin
                  half_r <= 1'b1;
               end else begin
                  ei_r <= ei_r + 3'h1;
                  ej_r <= m1;
               end
            end else if (ej_r != m1) begin
               ej_r <= ej_r + 6'h01;
            end else begin
               ei_r <= ei_r - 3'h1;
               ej_r <= 6'h00;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Push arbiter and two-entry output buffer
   // ---------------------------------------------------------------
   reg [16:0] b0_r, b1_r;
   reg [1:0] bn_r;
   wire in_ready = (bn_r != 2'h2);
   wire any = mk_pend_r | done_r | tst_pend_r;
   wire push = any & in_ready;
   wire pop = out_ready & (bn_r != 2'h0);
   wire [16:0] pd = mk_pend_r ? {1'b1, mark_r} : done_r ? {1'b0, res_r} : {1'b0, tst_val_r};
   assign mk_take = push & mk_pend_r;
   assign eng_take = push & ~mk_pend_r & done_r;
   assign tst_take = push & ~mk_pend_r & ~done_r;
   assign out_valid = (bn_r != 2'h0);
   assign out_word = b0_r[15:0];
   assign out_marker = b0_r[16];

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         b0_r <= 17'h00000;
         b1_r <= 17'h00000;
         bn_r <= 2'h0;
      end else begin
         bn_r <= bn_r + {1'b0, push} - {1'b0, pop};
         if (pop) begin
            if (bn_r == 2'h2) begin
               b0_r <= b1_r;
               if (push) begin
                  b1_r <= pd;
               end
            end else if (push) begin
               b0_r <= pd;
            end
         end else if (push) begin
            if (bn_r == 2'h0) begin
               b0_r <= pd;
            end else begin
               b1_r <= pd;
            end
         end
      end
   end
endmodule // dcf_core
`default_nettype wire

// ==== dcf_core_sva.sv ====
// Port checker of the coefficient FIR block
`timescale 1ns/10ps
`default_nettype none
module dcf_core_sva (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Pins
   input wire logic sen_n,
   input wire logic adc_clk,
   input wire logic tx_sync,
   input wire logic [5:0] prof_dec_ratio,
   // Outputs
   input wire logic offset_removal_skip,
   input wire logic mixer_skip,
   input wire logic remodulator_skip,
   input wire logic mixer_phase_reset,
   input wire logic [15:0] out_word,
   input wire logic out_marker,
   input wire logic out_valid,
   input wire logic out_ready
);
   // ---------------------------------------------------------------
   // Helper logic
   // ---------------------------------------------------------------
   logic sen_q_r, adc_q_r, tx_q_r, armed_r;
   logic [7:0] sen_age_r, tx_age_r, falls_r, k_lo;
   logic [5:0] ratio_r;
   assign k_lo = 8'h12 + ((ratio_r == 6'h00) ? 8'h01 : (ratio_r > 6'h20) ? 8'h20 : {2'b00, ratio_r});
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sen_q_r <= 1'b1;
         adc_q_r <= 1'b0;
         tx_q_r <= 1'b0;
         armed_r <= 1'b0;
         sen_age_r <= 8'hFF;
         tx_age_r <= 8'hFF;
         falls_r <= 8'h00;
         ratio_r <= 6'h00;
      end else begin
         sen_q_r <= sen_n;
         adc_q_r <= adc_clk;
         tx_q_r <= tx_sync;
         sen_age_r <= (sen_n && !sen_q_r) ? 8'h00 : sen_age_r + {7'h00, sen_age_r != 8'hFF};
         if (tx_sync && !tx_q_r) begin
            tx_age_r <= 8'h00;
            armed_r <= 1'b1;
            falls_r <= 8'h00;
            ratio_r <= prof_dec_ratio;
         end else begin
            tx_age_r <= tx_age_r + {7'h00, tx_age_r != 8'hFF};
            falls_r <= falls_r + {7'h00, adc_q_r && !adc_clk};
            if (out_valid && out_marker) armed_r <= 1'b0;
         end
      end
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_held;
      out_valid && !out_ready;
   endsequence
   sequence s_mark_up;
      $rose(out_valid && out_marker);
   endsequence
   a_valid_holds: assert property (s_held |=> out_valid)
      else $error("word lost while stalled");
   a_word_holds: assert property (s_held |=> $stable(out_word) && $stable(out_marker))
      else $error("head word changed while stalled");
   a_phase_single: assert property (mixer_phase_reset |=> !mixer_phase_reset)
      else $error("phase reset pulse too long");
   a_phase_cause: assert property (mixer_phase_reset |-> tx_age_r < 8'h3C)
      else $error("phase reset without sync");
   a_skip_cause: assert property ($changed({offset_removal_skip, mixer_skip, remodulator_skip}) |-> sen_age_r < 8'h0C)
      else $error("skip bits changed without a write");
   a_marker_armed: assert property (s_mark_up |-> armed_r)
      else $error("marker without sync");
   a_marker_delay: assert property (s_mark_up |-> falls_r >= k_lo && falls_r <= k_lo + 8'h02)
      else $error("marker delay wrong");
   a_start_idle: assert property (!$past(rst_n) |-> !out_valid && !mixer_skip)
      else $error("active right after reset");
endmodule // dcf_core_sva
bind dcf_core dcf_core_sva dcf_core_sva_i (.sys_clk, .rst_n, .sen_n, .adc_clk, .tx_sync, .prof_dec_ratio,
   .offset_removal_skip, .mixer_skip, .remodulator_skip, .mixer_phase_reset, .out_word, .out_marker,
   .out_valid, .out_ready);
`default_nettype wire

// ==== dcf_host_model.sv ====
// Serial port host model of the coefficient FIR block
`timescale 1ns/10ps
`default_nettype none
module dcf_host_model (
   // Serial pins
   output logic sclk,
   output logic sen_n,
   output logic sdata,
   output logic demod_port_select
);
   initial begin
      sclk = 1'b1;
      sen_n = 1'b1;
      sdata = 1'b0;
      demod_port_select = 1'b1;
   end
   // Address byte then n data bits, MSB first, 160 ns clock only within frames
   task automatic send(input logic [7:0] a, input logic [111:0] d, input int n, input logic sel);
      logic [119:0] f;
      f = {a, d << (112 - n)};
      demod_port_select = sel;
      #100;
      sen_n = 1'b0;
      for (int b = 0; b < n + 8; b++) begin
         sclk = 1'b0;
         sdata = f[119 - b];
         #80;
         sclk = 1'b1;
         #80;
      end
      sen_n = 1'b1;
      sdata = ~sdata;
      #100;
      demod_port_select = 1'b1;
      #100;
   endtask
endmodule // dcf_host_model
`default_nettype wire

// ==== demod_coeff_ram_fir_timing_tb_top.sv ====
// Testbench of the coefficient FIR block
`timescale 1ns/10ps
`default_nettype none
module demod_coeff_ram_fir_timing_tb_top;
   logic sys_clk, rst_n, adc_clk, tx_sync, out_ready, out_valid, out_marker, listen, started;
   logic sclk, sen_n, sdata, demod_port_select, offset_removal_skip, mixer_skip, remodulator_skip, mixer_phase_reset;
   logic [13:0] adc_data;
   logic [13:0] c[16];
   logic [7:0] prof_coef_ptr;
   logic [5:0] prof_dec_ratio;
   logic [15:0] out_word, mark_val;
   logic [16:0] exp_q[$];
   logic [111:0] bw;
   logic signed [13:0] xs[2048];
   int n_errors, samples_checked, seed, adc_div, n_phase, n_rise;
   dcf_core dcf_core_i (.sys_clk, .rst_n, .sclk, .sen_n, .sdata, .demod_port_select, .adc_clk, .tx_sync,
      .adc_data, .prof_coef_ptr, .prof_dec_ratio, .offset_removal_skip, .mixer_skip, .remodulator_skip,
      .mixer_phase_reset, .out_word, .out_marker, .out_valid, .out_ready);
   dcf_host_model dcf_host_model_i (.sclk, .sen_n, .sdata, .demod_port_select);
   // ---------------------------------------------------------------
   // Clocks, sample stream and monitor
   // ---------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(negedge sys_clk) begin
      adc_div <= (adc_div == 11) ? 0 : adc_div + 1;
      out_ready <= |2'($random(seed));
      if (adc_div == 11) begin
         adc_clk <= ~adc_clk;
         if (adc_clk) adc_data <= 14'($random(seed));
         if (!adc_clk) xs[n_rise] <= adc_data;
         if (!adc_clk) n_rise <= n_rise + 1;
      end
   end
   always @(posedge sys_clk) begin
      if (mixer_phase_reset === 1'b1) n_phase++;
      if (listen && out_valid === 1'b1 && out_ready === 1'b1) begin
         if (out_marker === 1'b1) started = 1'b1;
         if (started && exp_q.size() > 0) chk({out_marker, out_word}, exp_q.pop_front(), "stream word");
      end
   end
   task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      dcf_host_model_i.send(a, {96'h0, d}, 16, 1'b0);
   endtask
   // ---------------------------------------------------------------
   // Tap readout or filtered output after a sync edge
   // ---------------------------------------------------------------
   task automatic readout(input logic [7:0] pptr, input logic [15:0] ovr, input bit filt);
      logic [13:0] x;
      longint y;
      int n0;
      wr(8'h1F, ovr);
      if (filt) wr(8'h1D, 16'h00E0);
      @(negedge sys_clk);
      prof_coef_ptr = pptr;
      exp_q.push_back({1'b1, mark_val});
      if (!filt) begin
         exp_q.push_back(17'h00000);
         for (int i = 0; i < 32; i++) begin
            x = c[(i < 16 ? i : 31 - i) < 8 ? 2 * (i < 16 ? i : 31 - i) + 1 : 30 - 2 * (i < 16 ? i : 31 - i)];
            exp_q.push_back({1'b0, {2{x[13]}}, x});
         end
         exp_q.push_back(17'h00000);
      end
      started = 1'b0;
      listen = 1'b1;
      n_phase = 0;
      @(negedge adc_clk);
      @(negedge sys_clk);
      n0 = n_rise;
      tx_sync = 1'b1;
      repeat (40) @(negedge sys_clk);
      tx_sync = 1'b0;
      // First kept sample is the rise after marker start, 16+M+1 periods after the latched fall
      for (int s = 0; filt && s < 8; s++) begin
         wait (n_rise > n0 + 20 + 2 * s);
         y = 0;
         for (int t = 0; t < 32; t++) y += $signed(c[t < 16 ? t : 31 - t]) * xs[n0 + 20 + 2 * s - t];
         exp_q.push_back({1'b0, 16'(y >>> 14)});
      end
      for (int t = 0; t < 4000 && exp_q.size() > 0; t++) @(negedge sys_clk);
      chk(17'(exp_q.size()), 17'h00000, "words missing");
      chk(17'(n_phase), 17'h00001, "phase resets");
      listen = 1'b0;
      $display("test readout base %h filter %0d done", pptr, filt);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      #400000;
      n_errors++;
      give_verdict();
   end
   initial begin
      rst_n = 1'b0;
      tx_sync = 1'b0;
      out_ready = 1'b1;
      adc_clk = 1'b0;
      adc_data = 14'h0000;
      adc_div = 0;
      prof_coef_ptr = 8'h00;
      prof_dec_ratio = 6'h02;
      seed = 32'h2e32456d;
      n_errors = 0;
      samples_checked = 0;
      listen = 1'b0;
      started = 1'b0;
      n_phase = 0;
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (10) @(negedge sys_clk);
      for (int n = 0; n < 16; n++) c[n] = 14'($random(seed));
      dcf_host_model_i.send(8'h16, 112'h0, 16, 1'b1);
      wr(8'hC6, 16'h0010);
      for (int j = 0; j < 2; j++) begin
         for (int i = 0; i < 8; i++) bw[14 * i +: 14] = c[2 * (1 + i) - (1 + j)];
         dcf_host_model_i.send(8'hC7, bw, 112, 1'b0);
      end
      wr(8'h0A, 16'h6405);
      @(negedge sys_clk);
      chk({14'h0000, offset_removal_skip, mixer_skip, remodulator_skip}, 17'h00007, "skip bits");
      wr(8'hC3, 16'h6800);
      wr(8'h1D, 16'h01E0);
      mark_val = 16'($random(seed));
      wr(8'h0B, mark_val);
      dcf_host_model_i.send(8'h0B, {96'h0, ~mark_val}, 16, 1'b1);
      $display("test set-up done");
      readout(8'h10, 16'h0000, 1'b0);
      readout(8'h33, 16'h8800, 1'b0);
      readout(8'h10, 16'h0000, 1'b1);
      give_verdict();
   end
endmodule // demod_coeff_ram_fir_timing_tb_top
`default_nettype wire
